// >>> logic/rmog_regs.svh
/*
  Timing and threshold constants for the roller motor overload guard.
  Assumes a 25 ns system clock and a 100 ms timebase tick.
*/
`ifndef RMOG_REGS_SVH
`define RMOG_REGS_SVH

// system clock period
`define RMOG_CLK_NS        25
// timebase tick length
`define RMOG_TICK_NS       100000000
`define RMOG_TICK_MS       100
// clock cycles per tick
`define RMOG_TICK_CYC      ((`RMOG_TICK_NS) / (`RMOG_CLK_NS))

// stall retry: on time and repeat period
`define RMOG_RETRY_ON_MS   1000
`define RMOG_RETRY_PER_MS  3000
// slow retry repeat period after the fast retries
`define RMOG_SLOW_PER_MS   60000
// speed deviation tolerated before shutdown
`define RMOG_LOW_MS        10000
// pause after a low speed shutdown
`define RMOG_LOW_WAIT_MS   60000
// near-zero speed held this long counts as a stall
`define RMOG_STALL_MS      500

// the same times as tick counts
`define RMOG_ON_T       ((`RMOG_RETRY_ON_MS) / (`RMOG_TICK_MS))
`define RMOG_OFF_T      ((`RMOG_RETRY_PER_MS - `RMOG_RETRY_ON_MS) / (`RMOG_TICK_MS))
`define RMOG_SLOW_OFF_T ((`RMOG_SLOW_PER_MS - `RMOG_RETRY_ON_MS) / (`RMOG_TICK_MS))
`define RMOG_LOW_T      ((`RMOG_LOW_MS) / (`RMOG_TICK_MS))
`define RMOG_WAIT_T     ((`RMOG_LOW_WAIT_MS) / (`RMOG_TICK_MS))
`define RMOG_STALL_T    ((`RMOG_STALL_MS) / (`RMOG_TICK_MS))

// fast retries before the error and the slow cycle
`define RMOG_MAX_TRIES     10
// speed at or below this counts as standing still
`define RMOG_STALL_SPEED   8'h02
// allowed deviation is one fifth (20 %) of the selected speed
`define RMOG_DEV_DIV       5

`endif

// >>> logic/rmog_pkg.sv
/*
  Types and the speed band check of the roller motor overload guard.
  Assumes rmog_regs.svh is on the include path.
*/
`include "rmog_regs.svh"

package rmog_pkg;

  // supervisor states, one-hot
  typedef enum logic [7:0]
  {
    ST_HOLD     = 8'h01,
    ST_RUN      = 8'h02,
    ST_TRY_OFF  = 8'h04,
    ST_TRY_ON   = 8'h08,
    ST_SLOW_OFF = 8'h10,
    ST_SLOW_ON  = 8'h20,
    ST_LOW_WAIT = 8'h40,
    ST_HOT      = 8'h80
  } rmog_state_t;

  // pin level inputs from outside the clock domain
  typedef struct packed
  {
    logic start;      // start request from the control system
    logic motor_hot;  // motor over its temperature limit
    logic elec_hot;   // drive electronics over their limit
  } rmog_pins_t;

  // true when the measured speed is more than 20 % off the selected one
  function automatic logic rmog_off_speed(input logic [7:0] meas,
                                          input logic [7:0] sel);
    logic [7:0]  diff;
    logic [10:0] scaled;
    diff   = (meas > sel) ? (meas - sel) : (sel - meas);
    scaled = {3'h0, diff} * 11'(`RMOG_DEV_DIV);
    return scaled > {3'h0, sel};
  endfunction : rmog_off_speed

endpackage : rmog_pkg

// >>> logic/rmog_sync.sv
/*
  Three-stage synchroniser with agreement filter for the pin inputs.
  Assumes the inputs are asynchronous levels; output follows once
  the second and third stages agree.
*/
`timescale 1ns/1ps

module rmog_sync
  import rmog_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // raw pins and filtered result
  input  wire rmog_pkg::rmog_pins_t pin_in,
  output      rmog_pkg::rmog_pins_t pin_out
);

  rmog_pins_t s1;  // first stage, read only by s2
  rmog_pins_t s2;  // second stage
  rmog_pins_t s3;  // third stage

  // shift chain
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // per bit, take the new level only when two stages agree
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pin_out <= '0;
    else
      pin_out <= (s2 & s3) | (pin_out & (s2 | s3));
  end

endmodule : rmog_sync

// >>> logic/rmog_guard.sv
/*
  Overload supervisor of a motorised conveyor roller: stall retries,
  low speed shutdown, over-temperature shutdown and zero-motion hold.
  Assumes speed feedback and selected speed come from logic on CLK;
  start and temperature flags are asynchronous pins.
*/
`timescale 1ns/1ps

`include "rmog_regs.svh"

// How it works
// - blocked: one second retry every three seconds
// - error after tenth failed retry
// - then one second retry every sixty seconds
// - error clears at speed or start withdrawn
// - over twenty percent off for ten seconds: stop
// - low speed stop: restart after sixty seconds
// - motor or electronics hot: stop, error
// - over-temperature error clears once cooled
// - still started after cooling: may run again
// - no start: hold roller electronically
module rmog_guard
  import rmog_pkg::*;
#(
  parameter int unsigned TICK_CYC = `RMOG_TICK_CYC  // cycles per 100 ms tick
)
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_B,
  // control system and temperature pins
  input  wire rmog_pkg::rmog_pins_t PINS,
  // speed feedback and set point
  input  wire logic [7:0] SPEED_MEAS,
  input  wire logic [7:0] SPEED_SEL,
  // motor drive and status
  output      logic       MOTOR_ON,
  output      logic       BRAKE_ON,
  output      logic       ERROR
);

  // tick counts as compare values
  localparam logic [21:0] TICK_LAST  = 22'(TICK_CYC - 1);
  localparam logic [9:0]  ON_LAST    = 10'(`RMOG_ON_T - 1);
  localparam logic [9:0]  OFF_LAST   = 10'(`RMOG_OFF_T - 1);
  localparam logic [9:0]  SLOW_LAST  = 10'(`RMOG_SLOW_OFF_T - 1);
  localparam logic [9:0]  WAIT_LAST  = 10'(`RMOG_WAIT_T - 1);
  localparam logic [6:0]  STALL_LAST = 7'(`RMOG_STALL_T - 1);
  localparam logic [6:0]  LOW_FULL   = 7'(`RMOG_LOW_T);
  localparam logic [3:0]  TRY_LAST   = 4'(`RMOG_MAX_TRIES - 1);

  rmog_pins_t  pins;        // synchronised pins
  rmog_state_t st;          // current state
  rmog_state_t next_st;     // next state
  logic [21:0] tick_cnt;    // timebase divider
  logic [9:0]  tmr;         // ticks spent in the current state
  logic [3:0]  tries;       // fast retries done
  logic [6:0]  dev_cnt;     // ticks spent off speed in the current state
  logic        next_error;  // next error level
  logic        next_motor;  // next motor enable
  logic        next_brake;  // next holding brake

  // pin synchroniser
  rmog_sync u_sync
  (
    .clk     (CLK),
    .rst_b   (RST_B),
    .pin_in  (PINS),
    .pin_out (pins)
  );

  // decoded conditions
  wire start     = pins.start;
  wire hot_any   = pins.motor_hot | pins.elec_hot;
  wire off_speed = rmog_off_speed(SPEED_MEAS, SPEED_SEL);
  wire at_speed  = !off_speed;
  wire near_zero = SPEED_MEAS <= `RMOG_STALL_SPEED;
  wire tick      = tick_cnt == TICK_LAST;
  wire st_change = next_st != st;
  wire on_end    = tick && (tmr == ON_LAST);
  wire off_end   = tick && (tmr == OFF_LAST);
  wire slow_end  = tick && (tmr == SLOW_LAST);
  wire wait_end  = tick && (tmr == WAIT_LAST);
  wire tries_done = tries == TRY_LAST;
  wire stall_trip = (st == ST_RUN) && off_speed && near_zero && tick &&
                    (dev_cnt >= STALL_LAST);
  wire low_trip  = (st == ST_RUN) && off_speed && tick && (dev_cnt == LOW_FULL);
  wire try_fail  = (st == ST_TRY_ON) && on_end && tries_done && off_speed;
  // motor is driven in these states
  wire drive_st  = (next_st == ST_RUN) || (next_st == ST_TRY_ON) ||
                   (next_st == ST_SLOW_ON);

  // state transitions
  always_comb
  begin
    next_st = st;
    if (hot_any)
      next_st = ST_HOT;
    else if (!start)
      next_st = ST_HOLD;
    else
      case (st)
        // started, or cooled with start still set
        ST_HOLD, ST_HOT:
          next_st = ST_RUN;
        // running: watch for stall and low speed
        ST_RUN:
          if (stall_trip)
            next_st = ST_TRY_OFF;
          else if (low_trip)
            next_st = ST_LOW_WAIT;
        ST_TRY_OFF:
          if (off_end)
            next_st = ST_TRY_ON;
        ST_TRY_ON:
          if (at_speed)
            next_st = ST_RUN;
          else if (on_end)
            next_st = tries_done ? ST_SLOW_OFF : ST_TRY_OFF;
        // long pause of the slow cycle
        ST_SLOW_OFF:
          if (slow_end)
            next_st = ST_SLOW_ON;
        ST_SLOW_ON:
          if (at_speed)
            next_st = ST_RUN;
          else if (on_end)
            next_st = ST_SLOW_OFF;
        ST_LOW_WAIT:
          if (wait_end)
            next_st = ST_RUN;
        // unknown code: fall back to hold
        default:
          next_st = ST_HOLD;
      endcase
  end

  // error level: hot sets first, start withdrawn clears, then setting events win over clearing
  always_comb
  begin
    next_error = ERROR;
    if (hot_any)
      next_error = 1'b1;
    else if (!start)
      next_error = 1'b0;
    else if (try_fail || (low_trip && !stall_trip))
      next_error = 1'b1;
    else if (st == ST_HOT)
      next_error = 1'b0;
    else if (at_speed && ((st == ST_RUN) || (st == ST_TRY_ON) ||
                          (st == ST_SLOW_ON)))
      next_error = 1'b0;
  end

  // drive outputs follow the next state
  assign next_motor = drive_st;
  assign next_brake = next_st == ST_HOLD;

  // state register
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      st <= ST_HOLD;
    else
      st <= next_st;
  end

  // timebase, restarted on every state change
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      tick_cnt <= 22'h000000;
    else if (st_change || tick)
      tick_cnt <= 22'h000000;
    else
      tick_cnt <= tick_cnt + 22'h000001;
  end

  // ticks in state
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      tmr <= 10'h000;
    else if (st_change)
      tmr <= 10'h000;
    else if (tick)
      tmr <= tmr + 10'h001;
  end

  // count fast retries, cleared outside the retry loop
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      tries <= 4'h0;
    else if ((next_st == ST_RUN) || (next_st == ST_HOLD) || (next_st == ST_HOT))
      tries <= 4'h0;
    else if ((st == ST_TRY_ON) && on_end && !tries_done)
      tries <= tries + 4'h1;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      dev_cnt <= 7'h00;
    else if (st_change || at_speed)
      dev_cnt <= 7'h00;
    else if (tick && (dev_cnt != LOW_FULL))
      dev_cnt <= dev_cnt + 7'h01;
  end

  // registered outputs, brake held through reset
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      MOTOR_ON <= 1'b0;
      BRAKE_ON <= 1'b1;
      ERROR    <= 1'b0;
    end
    else
    begin
      MOTOR_ON <= next_motor;
      BRAKE_ON <= next_brake;
      ERROR    <= next_error;
    end
  end

  // checks on the supervisor

  a_hot_stop: assert property (
    @(posedge CLK) disable iff (!RST_B)
    hot_any |=> !MOTOR_ON && ERROR && (st == ST_HOT))
    else $error("motor not stopped on over-temperature");

  a_cool_resume: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (st == ST_HOT) && !hot_any && start |=> MOTOR_ON && !ERROR)
    else $error("no recovery after cooling");

  a_hold_brake: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !start && !hot_any |=> BRAKE_ON && !MOTOR_ON && !ERROR)
    else $error("roller not held without start");

  a_clear_speed: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (st == ST_TRY_ON) && at_speed && start && !hot_any
      |=> (st == ST_RUN) && MOTOR_ON && !ERROR)
    else $error("error kept after reaching speed");

  a_stall_retry: assert property (
    @(posedge CLK) disable iff (!RST_B)
    stall_trip && start && !hot_any |=> (st == ST_TRY_OFF) && !MOTOR_ON)
    else $error("stall did not stop the motor");

  a_retry_start: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (st == ST_TRY_OFF) && off_end && start && !hot_any
      |=> (MOTOR_ON && (st == ST_TRY_ON)) ##1 (tmr == 10'h000))
    else $error("retry did not start after pause");

  a_retry_limit: assert property (
    @(posedge CLK) disable iff (!RST_B)
    try_fail && start && !hot_any
      |=> ERROR && !MOTOR_ON && (st == ST_SLOW_OFF) && (tries == TRY_LAST))
    else $error("no error after last fast retry");

  a_slow_cycle: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (st == ST_SLOW_OFF) && slow_end && start && !hot_any
      |=> (st == ST_SLOW_ON) && MOTOR_ON && ERROR)
    else $error("slow cycle retry missing");

  // a slow retry that fails goes back to the long pause, error kept
  a_slow_retry_end: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (st == ST_SLOW_ON) && on_end && off_speed && start && !hot_any
      |=> (st == ST_SLOW_OFF) && !MOTOR_ON && ERROR)
    else $error("slow cycle retry did not end");

  a_low_trip: assert property (
    @(posedge CLK) disable iff (!RST_B)
    low_trip && !stall_trip && start && !hot_any
      |=> (st == ST_LOW_WAIT) && ERROR && !MOTOR_ON)
    else $error("low speed not shut down");

  a_low_restart: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (st == ST_LOW_WAIT) && wait_end && start && !hot_any
      |=> (st == ST_RUN) && MOTOR_ON && $stable(ERROR))
    else $error("no restart after low speed wait");

  // motor stays off with the error up until the wait has run out
  a_low_wait_hold: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (st == ST_LOW_WAIT) && !wait_end && start && !hot_any
      |=> (st == ST_LOW_WAIT) && !MOTOR_ON && ERROR)
    else $error("motor restarted before the wait ended");

endmodule : rmog_guard

// >>> testbench/rmog_ctl_model.sv
/*
  Model of the conveyor control system: drives start, watches error.
  Assumes the bench commands it on the rising edge of clk.
*/
`timescale 1ns/1ps

module rmog_ctl_model
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // bench command and recovery policy
  input  wire logic want,
  input  wire logic drop_on_err,
  // device side
  input  wire logic error,
  output      logic start
);
  logic gave_up;  // start withdrawn after a seen error

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      gave_up <= 1'b0;
    else if (!want)
      gave_up <= 1'b0;
    else if (drop_on_err && error)
      gave_up <= 1'b1;
  end

  // start follows the command until we give up
  assign start = want && !gave_up;
endmodule : rmog_ctl_model

// >>> testbench/rmog_guard_tb.sv
/*
  Self-checking bench of the overload guard with a short tick.
  Assumes rmog_pkg is compiled first and the control model exists.
*/
`timescale 1ns/1ps

module rmog_guard_tb;
  import rmog_pkg::*;
  localparam int TICK = 4;         // cycles per tick
  localparam int CPS  = 10 * TICK; // cycles per second
  logic       CLK, RST_B, want, drop_on_err, ctl_start;
  logic [1:0] hot;                  // motor_hot, elec_hot
  logic [7:0] SPEED_MEAS, SPEED_SEL;
  logic       MOTOR_ON, BRAKE_ON, ERROR;
  rmog_pins_t pins;
  int         num_errors, n_checks, seed, n, sel;
  int         exp_q[$];             // rules model: expected segment lengths
  int         exp_n;                // segment length taken from the model

  assign pins = {ctl_start, hot};

  // device under test
  rmog_guard #(.TICK_CYC(TICK)) u_rmog_guard
  (
    .CLK        (CLK),
    .RST_B      (RST_B),
    .PINS       (pins),
    .SPEED_MEAS (SPEED_MEAS),
    .SPEED_SEL  (SPEED_SEL),
    .MOTOR_ON   (MOTOR_ON),
    .BRAKE_ON   (BRAKE_ON),
    .ERROR      (ERROR)
  );

  // far side control system
  rmog_ctl_model u_rmog_ctl_model
  (
    .clk         (CLK),
    .rst_b       (RST_B),
    .want        (want),
    .drop_on_err (drop_on_err),
    .error       (ERROR),
    .start       (ctl_start)
  );

  // compare one output bit
  task automatic chk(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : chk

  // compare a measured length against a window
  task automatic chk_n(input int got, input int lo, input int hi, input string what);
    n_checks++;
    if (got < lo || got > hi)
    begin
      num_errors++;
      $display("Error at %0t: %s length %0d", $time, what, got);
    end
  endtask : chk_n

  // wait k edges, then let outputs settle
  task automatic cyc(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask : cyc

  // count edges while MOTOR_ON holds lvl, bounded
  task automatic seg(input logic lvl, input int lim);
    n = 0;
    while (n < lim)
    begin
      @(posedge CLK);
      #1;
      n++;
      if (MOTOR_ON !== lvl)
        break;
    end
  endtask : seg

  // verdict and end of run
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // clock
  initial
  begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // watchdog against hangs
  initial
  begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    $display("Error at %0t: watchdog", $time);
    print_verdict();
  end

  // main sequence
  initial
  begin
    seed = 46707;
    sel = 50 + ($random(seed) & 63);
    {RST_B, want, drop_on_err, hot} = '0;
    SPEED_SEL = 8'(sel);
    SPEED_MEAS = 8'h00;
    num_errors = 0;
    n_checks = 0;
    cyc(16);
    chk(BRAKE_ON, 1'b1, "hold in reset");
    chk(MOTOR_ON | ERROR, 1'b0, "reset outputs");
    @(posedge CLK) RST_B <= 1'b1;
    // start at speed
    @(posedge CLK) want <= 1'b1;
    SPEED_MEAS <= 8'(sel);
    cyc(6);
    chk(MOTOR_ON & ~BRAKE_ON, 1'b1, "run on start");
    // exactly 20 % off either way is tolerated
    @(posedge CLK) SPEED_MEAS <= 8'(sel - sel / 5);
    seg(1'b1, 12 * CPS);
    chk_n(n, 12 * CPS, 12 * CPS, "low band edge");
    @(posedge CLK) SPEED_MEAS <= 8'(sel + sel / 5);
    seg(1'b1, 12 * CPS);
    chk_n(n, 12 * CPS, 12 * CPS, "high band edge");
    // more than 20 % low trips after ten seconds
    @(posedge CLK) SPEED_MEAS <= 8'(sel - sel / 4);
    seg(1'b1, 12 * CPS);
    chk_n(n, 10 * CPS + 1, 10 * CPS + TICK + 2, "low speed trip");
    cyc(1);
    chk(ERROR, 1'b1, "low speed error");
    seg(1'b0, 70 * CPS);
    chk_n(n, 60 * CPS - 1, 60 * CPS, "low speed wait");
    chk(ERROR, 1'b1, "error kept on restart");
    @(posedge CLK) SPEED_MEAS <= 8'(sel);
    cyc(4);
    chk(ERROR, 1'b0, "clear at speed");
    // second trip above the band, control system withdraws start
    @(posedge CLK) drop_on_err <= 1'b1;
    SPEED_MEAS <= 8'(sel + sel / 4);
    seg(1'b1, 12 * CPS);
    chk_n(n, 10 * CPS + 1, 10 * CPS + TICK + 2, "high speed trip");
    cyc(8);
    chk(ERROR | MOTOR_ON, 1'b0, "clear on withdraw");
    chk(BRAKE_ON, 1'b1, "hold after withdraw");
    @(posedge CLK) drop_on_err <= 1'b0;
    want <= 1'b0;
    SPEED_MEAS <= 8'(sel);
    cyc(2);
    @(posedge CLK) want <= 1'b1;
    cyc(6);
    // each temperature flag stops and recovers
    for (int k = 0; k < 2; k++)
    begin
      @(posedge CLK) hot <= 2'(1 << k);
      cyc(6);
      chk(MOTOR_ON, 1'b0, "hot stops motor");
      chk(ERROR, 1'b1, "hot error");
      @(posedge CLK) hot <= 2'h0;
      cyc(6);
      chk(ERROR, 1'b0, "cooled clears");
      chk(MOTOR_ON, 1'b1, "resume while started");
    end
    // stall: ten fast retries then the slow cycle
    @(posedge CLK) SPEED_MEAS <= 8'h00;
    seg(1'b1, 100);
    chk_n(n, 4 * TICK, 6 * TICK + 2, "stall detect");
    // rules model: 2 s off, 1 s on ten times, then 59 s off, 1 s on, 59 s off
    for (int i = 0; i < 10; i++)
    begin
      exp_q.push_back(2 * CPS);
      exp_q.push_back(CPS);
    end
    exp_q.push_back(59 * CPS);
    exp_q.push_back(CPS);
    exp_q.push_back(59 * CPS);
    // even segments have the motor off, odd ones on
    for (int i = 0; i < 23; i++)
    begin
      exp_n = exp_q.pop_front();
      seg(1'(i % 2), 70 * CPS);
      if (i >= 20)
        chk_n(n, exp_n, exp_n, "slow cycle segment");
      else if (i % 2 == 0)
        chk_n(n, exp_n, exp_n, "retry pause");
      else
        chk_n(n, exp_n, exp_n, "retry length");
      if (i < 19)
        chk(ERROR, 1'b0, "no error during retries");
      else
        chk(ERROR, 1'b1, "error after ten");
    end
    @(posedge CLK) SPEED_MEAS <= 8'(sel);
    cyc(4);
    chk(ERROR, 1'b0, "stall cleared at speed");
    cyc(2 * CPS);
    chk(MOTOR_ON, 1'b1, "running again");
    @(posedge CLK) want <= 1'b0;
    cyc(6);
    chk(BRAKE_ON & ~MOTOR_ON, 1'b1, "hold when idle");
    print_verdict();
  end
endmodule : rmog_guard_tb
